// ---- sim/adc_core_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module adc_core_model
   import adc_ctrl_pkg::*;
#(
   parameter int SLOW_CYC = 200
)
(
   input  wire logic        clk_i,
   input  wire logic        core_clk_en_i,
   input  wire logic        core_power_i,
   input  wire logic        core_start_i,
   input  wire logic        core_abort_i,
   input  wire logic        slow_i,
   input  wire logic [11:0] value_i,
   output logic             core_done_o,
   output logic [11:0]      core_data_o
);
   int cnt  = 0;   // cycles left in the conversion
   int hold = 0;   // cycles left with done raised
   initial core_done_o = 1'b0;
   initial core_data_o = 12'hFFF;
   // ---------------------
   // conversion timer
   // ---------------------
   // done stays up four cycles so a two-stage synchroniser cannot miss it;
   // data is valid only around done and inverted otherwise
   always @(posedge clk_i) begin
      if (hold > 0) hold <= hold - 1;
      if (hold == 1) begin
         core_done_o <= 1'b0;
         core_data_o <= ~core_data_o;
      end
      if (core_abort_i || !core_clk_en_i || !core_power_i) begin
         cnt <= 0;
      end else if (core_start_i) begin
         cnt         <= slow_i ? SLOW_CYC : CONVERSION_ACTIVE_CYC;
         core_data_o <= ~value_i;
      end else if (cnt > 0) begin
         cnt <= cnt - 1;
         if (cnt == 4) core_data_o <= value_i;
         if (cnt == 1) begin
            core_done_o <= 1'b1;
            hold        <= 4;
         end
      end
   end
endmodule // adc_core_model
`default_nettype wire

// ---- sim/adc_ctrl_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl_properties
   import adc_ctrl_pkg::*;
(
   input wire logic        clk_i,
   input wire logic        rstn_i,
   input wire logic [11:0] s_awaddr_i,
   input wire logic        s_awvalid_i,
   input wire logic        s_awready_o,
   input wire logic [31:0] s_wdata_i,
   input wire logic        sleep_i,
   input wire logic        idle_i,
   input wire logic        core_clk_en_o,
   input wire logic        core_power_o,
   input wire logic        core_abort_o,
   input wire logic        conversion_active_irq_o,
   input wire logic        wake_o,
   input wire logic        conversion_active_o
);
   // ---------------------
   // control mirror
   // ---------------------
   logic       ctl_wr;
   logic [3:0] mir_r;
   logic [3:0] mir_nxt;
   // low nibble only: power, rc clock, stop in idle, irq enable
   assign ctl_wr = s_awvalid_i && s_awready_o && (s_awaddr_i == CTRL_ADDR);
   always_comb mir_nxt = ctl_wr ? s_wdata_i[3:0] : mir_r;
   always_ff @(posedge clk_i) mir_r <= rstn_i ? mir_nxt : 4'h0;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   // ---------------------
   // assertions
   // ---------------------
   // five cycles leave room for the two-stage synchroniser
   a_reset_state: assert property ($rose(rstn_i) |-> core_abort_o && !core_power_o
      && !conversion_active_o && !conversion_active_irq_o) else $error("reset state wrong");
   a_off_dark: assert property (!core_power_o [*2] |-> !core_clk_en_o
      && !conversion_active_o) else $error("unpowered block still clocked");
   a_power_follows: assert property (ctl_wr && s_wdata_i[CTRL_PWR] && !sleep_i
      |-> ##[1:3] core_power_o) else $error("power on not applied");
   a_sleep_gates: assert property ((sleep_i && !mir_r[CTRL_RC]) [*5]
      |-> !core_clk_en_o) else $error("clock runs in sleep");
   a_sleep_aborts: assert property ((sleep_i && !mir_r[CTRL_RC]) [*5]
      |-> !conversion_active_o) else $error("conversion survives sleep");
   a_irq_single: assert property (conversion_active_irq_o |=> !conversion_active_irq_o)
      else $error("irq longer than one cycle");
   a_done_idle: assert property (conversion_active_irq_o |-> !conversion_active_o)
      else $error("active still set at completion");
   a_wake_cause: assert property (wake_o |-> mir_r[CTRL_IE])
      else $error("wake without irq enable");
   a_idle_halts: assert property ((idle_i && mir_r[CTRL_SIDL]) [*5]
      |-> !core_clk_en_o) else $error("clock runs in idle");
   c_rc_done: cover property (conversion_active_irq_o && mir_r[CTRL_RC]);
   c_wake: cover property (wake_o);
   c_sleep_busy: cover property (sleep_i && conversion_active_o);
endmodule // adc_ctrl_properties
bind adc_power_sleep_format_ctrl adc_ctrl_properties adc_ctrl_properties_inst (
   .clk_i, .rstn_i, .s_awaddr_i, .s_awvalid_i, .s_awready_o, .s_wdata_i, .sleep_i,
   .idle_i, .core_clk_en_o, .core_power_o, .core_abort_o, .conversion_active_irq_o, .wake_o,
   .conversion_active_o);
`default_nettype wire

// ---- sim/adc_power_sleep_format_ctrl_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module adc_power_sleep_format_ctrl_tb;
   import adc_ctrl_pkg::*;
   logic        clk_i = '0, rstn_i = '0, s_awvalid_i = '0, s_wvalid_i = '0, s_bready_i = '0;
   logic        s_arvalid_i = '0, s_rready_i = '0, sleep_i = '0, idle_i = '0, slow = '0;
   logic [11:0] s_awaddr_i = '0, s_araddr_i = '0, nd = '0, core_data_i;
   logic [31:0] s_wdata_i = '0, s_rdata_o, rv, seed = 32'h0000_0002;
   logic [3:0]  s_wstrb_i = 4'hF;
   logic [1:0]  s_bresp_o, s_rresp_o, rsp;
   logic        s_awready_o, s_wready_o, s_bvalid_o, s_arready_o, s_rvalid_o, core_done_i;
   logic        core_clk_en_o, core_power_o, core_start_o, core_abort_o, conversion_active_irq_o, wake_o;
   logic        conversion_active_o, wake_seen = '0;
   int          cyc = 0, st_cyc = 0, bcyc = 0, irq_cnt = 0, miscompares = 0, checks_done = 0;
   adc_power_sleep_format_ctrl adc_power_sleep_format_ctrl_inst (.clk_i, .rstn_i, .s_awaddr_i,
      .s_awvalid_i, .s_awready_o, .s_wdata_i, .s_wstrb_i, .s_wvalid_i, .s_wready_o, .s_bresp_o,
      .s_bvalid_o, .s_bready_i, .s_araddr_i, .s_arvalid_i, .s_arready_o, .s_rdata_o, .s_rresp_o,
      .s_rvalid_o, .s_rready_i, .sleep_i, .idle_i, .core_done_i, .core_data_i, .core_clk_en_o,
      .core_power_o, .core_start_o, .core_abort_o, .conversion_active_irq_o, .wake_o, .conversion_active_o);
   adc_core_model adc_core_model_inst (.clk_i, .core_clk_en_i(core_clk_en_o),
      .core_power_i(core_power_o), .core_start_i(core_start_o), .core_abort_i(core_abort_o),
      .slow_i(slow), .value_i(nd), .core_done_o(core_done_i), .core_data_o(core_data_i));
   always #25 clk_i = ~clk_i;
   // ---------------------
   // helpers
   // ---------------------
   task automatic tally_and_finish();
      if (miscompares == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   function automatic logic [31:0] fmt_exp(input logic [1:0] f, input logic [11:0] v);
      case (f)
         FMT_UINT: return {20'h0_0000, v};
         FMT_SINT: return {16'h0000, {4{v[11]}}, v};
         default:  return {16'h0000, v, 4'h0};
      endcase
   endfunction
   // cycle count, event tallies and the hang limit
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (core_start_o === 1'b1) st_cyc <= cyc;
      if (conversion_active_irq_o === 1'b1) irq_cnt <= irq_cnt + 1;
      if (wake_o === 1'b1) wake_seen <= 1'b1;
      if (cyc == 20000) begin
         miscompares++;
         tally_and_finish();
      end
   end
   // address and data go out together; each released once taken
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_i);
      s_awaddr_i  <= a;
      s_wdata_i   <= d;
      s_awvalid_i <= 1'b1;
      s_wvalid_i  <= 1'b1;
      s_bready_i  <= 1'b1;
      do @(posedge clk_i); while (s_awready_o !== 1'b1);
      chk("wready", s_wready_o, 32'h1);
      s_awvalid_i <= 1'b0;
      s_wvalid_i  <= 1'b0;
      do @(posedge clk_i); while (s_bvalid_o !== 1'b1);
      s_bready_i <= 1'b0;
      rsp  = s_bresp_o;
      bcyc = cyc;
   endtask
   task automatic rd(input logic [11:0] a);
      @(posedge clk_i);
      s_araddr_i  <= a;
      s_arvalid_i <= 1'b1;
      s_rready_i  <= 1'b1;
      do @(posedge clk_i); while (s_arready_o !== 1'b1);
      s_arvalid_i <= 1'b0;
      do @(posedge clk_i); while (s_rvalid_o !== 1'b1);
      s_rready_i <= 1'b0;
      rv  = s_rdata_o;
      rsp = s_rresp_o;
   endtask
   task automatic conversion_active(input logic [31:0] c, input logic [11:0] v);
      nd <= v;
      wr(CTRL_ADDR, c | 32'h0000_0100);
      while (conversion_active_irq_o !== 1'b1) @(posedge clk_i);
   endtask
   // sleep follows the start request straight away
   task automatic sleep_conversion_active(input logic [31:0] c, input logic [11:0] v);
      nd        <= v;
      wake_seen <= 1'b0;
      wr(CTRL_ADDR, c | 32'h0000_0100);
      sleep_i <= 1'b1;
      repeat (60) @(posedge clk_i);
   endtask
   // ---------------------
   // main sequence
   // ---------------------
   initial begin
      logic [31:0] c;
      logic [11:0] v, a;
      logic [11:0] corner [4] = '{12'h800, 12'hFFF, 12'h7FF, 12'h001};
      int lat0, k;
      repeat (2) @(posedge clk_i);
      rstn_i <= 1'b1;
      rd(CTRL_ADDR);
      chk("ctrl_reset", rv, CTRL_RST);
      chk("off_outputs", {core_power_o, core_clk_en_o}, 32'h0);
      wr(CTRL_ADDR, 32'h0000_0001);
      chk("write_okay", rsp, RESP_OKAY);
      repeat (20) @(posedge clk_i);
      chk("power_on", core_power_o, 32'h1);
      // all four formats, system clock then rc clock
      for (int i = 0; i < 8; i++) begin
         seed = xs(seed);
         v = (i < 4) ? corner[i] : seed[11:0];
         c = 32'h1 | 32'((i % 4) << CTRL_FORM_L) | 32'((i / 4) << CTRL_RC);
         conversion_active(c, v);
         if (i == 0) lat0 = st_cyc - bcyc;
         if (i == 4) chk("rc_delay", st_cyc - bcyc, lat0 + INSTR_CYC);
         chk("active_clear", conversion_active_o, 32'h0);
         rd(RESULT_ADDR);
         chk("result", rv, fmt_exp(2'(i % 4), v));
      end
      rd(12'hFFC);
      chk("unmapped", rsp, RESP_SLVERR);
      wr(12'hFFC, 32'h0000_0000);
      chk("unmapped_wr", rsp, RESP_SLVERR);
      // sleep in mid-conversion on the system clock
      slow <= 1'b1;
      conversion_active(32'h0000_0001, 12'h000);
      wr(CTRL_ADDR, 32'h0000_0101);
      repeat (5) @(posedge clk_i);
      sleep_i <= 1'b1;
      k = irq_cnt;
      repeat (8) @(posedge clk_i);
      chk("sleep_clock", core_clk_en_o, 32'h0);
      chk("sleep_abort", conversion_active_o, 32'h0);
      sleep_i <= 1'b0;
      repeat (300) @(posedge clk_i);
      chk("no_resume", irq_cnt, k);
      rd(CTRL_ADDR);
      chk("sleep_regs", rv, 32'h0000_0001);
      idle_i <= 1'b1;
      repeat (8) @(posedge clk_i);
      chk("idle_run", core_clk_en_o, 32'h1);
      wr(CTRL_ADDR, 32'h0000_0005);
      repeat (8) @(posedge clk_i);
      chk("idle_halt", core_clk_en_o, 32'h0);
      idle_i <= 1'b0;
      slow   <= 1'b0;
      sleep_conversion_active(32'h0000_000B, 12'h9C3);
      chk("wake", wake_seen, 32'h1);
      sleep_i <= 1'b0;
      rd(RESULT_ADDR);
      chk("rc_sleep_result", rv, fmt_exp(2'h0, 12'h9C3));
      sleep_conversion_active(32'h0000_0003, 12'h3C9);
      chk("no_wake", wake_seen, 32'h0);
      chk("self_off", core_power_o, 32'h0);
      rd(CTRL_ADDR);
      chk("power_bit_kept", rv[0], 32'h1);
      rd(STATUS_ADDR);
      chk("sleep_off_flag", rv[1], 32'h1);
      sleep_i <= 1'b0;
      // reset during a conversion keeps the buffer
      wr(CTRL_ADDR, 32'h0000_0001);
      repeat (20) @(posedge clk_i);
      conversion_active(32'h0000_0001, 12'h5A3);
      rd(STATUS_ADDR);
      a = BUF_BASE + {6'h00, 4'(rv[5:2] - 4'h1), 2'h0};
      slow <= 1'b1;
      wr(CTRL_ADDR, 32'h0000_0101);
      repeat (10) @(posedge clk_i);
      rstn_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      chk("reset_abort", {core_abort_o, core_power_o, conversion_active_o}, 32'h4);
      rstn_i <= 1'b1;
      slow   <= 1'b0;
      rd(CTRL_ADDR);
      chk("ctrl_rereset", rv, CTRL_RST);
      rd(a);
      chk("buffer_kept", rv, fmt_exp(2'h0, 12'h5A3));
      tally_and_finish();
   end
endmodule // adc_power_sleep_format_ctrl_tb
`default_nettype wire

// ---- src/adc_ctrl_pkg.sv ----
package adc_ctrl_pkg;

   // -------------------------------------------------------------
   // register map (byte addresses)
   // -------------------------------------------------------------
   localparam logic [11:0] CTRL_ADDR    = 12'h000;
   localparam logic [11:0] STATUS_ADDR  = 12'h004;
   localparam logic [11:0] RESULT_ADDR  = 12'h008;
   localparam logic [11:0] BUF_BASE     = 12'h040;
   localparam int          BUF_DEPTH    = 16;
   localparam int          BUF_AW       = 4;

   // control field positions
   localparam int CTRL_PWR    = 0;
   localparam int CTRL_RC     = 1;
   localparam int CTRL_SIDL   = 2;
   localparam int CTRL_IE     = 3;
   localparam int CTRL_FORM_L = 4;
   localparam int CTRL_START  = 8;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;

   // timing
   localparam int CLK_HZ        = 20_000_000;
   localparam int INSTR_NS      = 50;
   localparam int INSTR_CYC     = (INSTR_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int CONVERSION_ACTIVE_CYC      = 14;
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // format codes
   typedef enum logic [1:0] {
      FMT_UINT  = 2'b00,
      FMT_SINT  = 2'b01,
      FMT_FRAC  = 2'b10,
      FMT_SFRAC = 2'b11
   } fmt_t;

   typedef enum logic [1:0] {
      CV_IDLE  = 2'b00,
      CV_DELAY = 2'b01,
      CV_RUN   = 2'b10
   } conversion_active_st_t;

   // control word as held by the block
   typedef struct packed {
      logic       pwr;
      logic       rc_sel;
      logic       sidl;
      logic       ie;
      fmt_t       form;
   } ctrl_t;

   // analog core handshake
   typedef struct packed {
      logic        done;
      logic [11:0] data;
   } core_res_t;

endpackage : adc_ctrl_pkg

// ---- src/adc_power_sleep_format_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
module adc_power_sleep_format_ctrl
   import adc_ctrl_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rstn_i,
   // axi4-lite slave
   input  wire logic [11:0] s_awaddr_i,
   input  wire logic        s_awvalid_i,
   output logic             s_awready_o,
   input  wire logic [31:0] s_wdata_i,
   input  wire logic [3:0]  s_wstrb_i,
   input  wire logic        s_wvalid_i,
   output logic             s_wready_o,
   output logic [1:0]       s_bresp_o,
   output logic             s_bvalid_o,
   input  wire logic        s_bready_i,
   input  wire logic [11:0] s_araddr_i,
   input  wire logic        s_arvalid_i,
   output logic             s_arready_o,
   output logic [31:0]      s_rdata_o,
   output logic [1:0]       s_rresp_o,
   output logic             s_rvalid_o,
   input  wire logic        s_rready_i,
   // system power state
   input  wire logic        sleep_i,
   input  wire logic        idle_i,
   // analog core
   input  wire logic        core_done_i,
   input  wire logic [11:0] core_data_i,
   output logic             core_clk_en_o,
   output logic             core_power_o,
   output logic             core_start_o,
   output logic             core_abort_o,
   // system side
   output logic             conversion_active_irq_o,
   output logic             wake_o,
   output logic             conversion_active_o
);

   // -------------------------------------------------------------
   // state
   // -------------------------------------------------------------
   typedef struct packed {
      ctrl_t       ctrl;
      conversion_active_st_t    st;
      logic [3:0]  dly;
      logic        sleep_off;
      logic        conversion_active_in_sleep;
      logic [BUF_AW-1:0] wptr;
      logic [11:0] last;
      logic        awr;
      logic        wr;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arr;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic        clk_en;
      logic        start;
      logic        abort;
      logic        irq;
      logic        wake;
      logic        go;
      logic        pwr_o;
      logic        active;
   } state_t;

   state_t r_r;
   state_t r_nxt;

   // buffer survives reset, kept out of the reset state
   logic [11:0] result_buffer [BUF_DEPTH];
   logic        buf_we;

   // synchronised external inputs
   logic [1:0] sleep_s_r;
   logic [1:0] idle_s_r;
   logic [1:0] done_s_r;
   logic       done_d_r;
   logic [11:0] data_s1_r;
   logic [11:0] data_s2_r;

   // format a stored result into the low 16 bits of the 32-bit read data
   function automatic logic [15:0] fmt_word(input fmt_t f, input logic [11:0] d);
      logic [15:0] w;
      w = 16'h0000;
      case (f)
         FMT_UINT:  w = {4'h0, d};
         FMT_SINT:  w = {{4{d[11]}}, d};
         default:   w = {d, 4'h0};
      endcase
      return w;
   endfunction

   // -------------------------------------------------------------
   // input synchronisers
   // -------------------------------------------------------------
   // core and power state arrive from other domains; two stages each
   always_ff @(posedge clk_i) begin
      sleep_s_r <= {sleep_s_r[0], sleep_i};
      idle_s_r  <= {idle_s_r[0], idle_i};
      done_s_r  <= {done_s_r[0], core_done_i};
      done_d_r  <= done_s_r[1];
      data_s1_r <= core_data_i;
      data_s2_r <= data_s1_r;
   end

   logic sleep_w;
   logic idle_w;
   logic done_w;
   assign sleep_w = sleep_s_r[1];
   assign idle_w  = idle_s_r[1];
   assign done_w  = done_s_r[1] & ~done_d_r;

   // -------------------------------------------------------------
   // next state
   // -------------------------------------------------------------
   always_comb begin
      logic        run_ok;
      logic        aw_go;
      logic [11:0] rd_addr;
      logic        start_req;
      run_ok    = 1'b0;
      r_nxt     = r_r;
      buf_we    = 1'b0;
      start_req = 1'b0;
      aw_go     = 1'b0;
      rd_addr   = s_araddr_i;
      r_nxt.start = 1'b0;
      r_nxt.abort = 1'b0;
      r_nxt.irq   = 1'b0;
      r_nxt.wake  = 1'b0;

      // ---- write channel: address and data in either order
      if (s_awvalid_i && !r_r.awr && !r_r.bvalid) begin
         r_nxt.awr = 1'b1;
      end
      if (s_wvalid_i && !r_r.wr && !r_r.bvalid) begin
         r_nxt.wr = 1'b1;
      end
      // awready and wready are one flop, high for the single cycle in which
      // both halves are held; address and data are taken at that edge
      aw_go = r_r.go;
      if (aw_go) begin
         r_nxt.awr    = 1'b0;
         r_nxt.wr     = 1'b0;
         r_nxt.bvalid = 1'b1;
         r_nxt.bresp  = RESP_OKAY;
         if (s_awaddr_i == CTRL_ADDR) begin
            // registers hold value through sleep; only writes change them
            if (s_wstrb_i[0]) begin
               r_nxt.ctrl.pwr    = s_wdata_i[CTRL_PWR];
               r_nxt.ctrl.rc_sel = s_wdata_i[CTRL_RC];
               r_nxt.ctrl.sidl   = s_wdata_i[CTRL_SIDL];
               r_nxt.ctrl.ie     = s_wdata_i[CTRL_IE];
               r_nxt.ctrl.form   = fmt_t'(s_wdata_i[CTRL_FORM_L +: 2]);
               if (s_wdata_i[CTRL_PWR]) begin
                  r_nxt.sleep_off = 1'b0;
               end
            end
            if (s_wstrb_i[1] && s_wdata_i[CTRL_START]) begin
               start_req = 1'b1;
            end
         end else if (s_awaddr_i != STATUS_ADDR && s_awaddr_i != RESULT_ADDR) begin
            r_nxt.bresp = RESP_SLVERR;
         end
      end
      if (r_r.bvalid && s_bready_i) begin
         r_nxt.bvalid = 1'b0;
      end

      // ---- read channel
      if (s_arvalid_i && !r_r.rvalid) begin
         r_nxt.rvalid = 1'b1;
         r_nxt.rresp  = RESP_OKAY;
         r_nxt.rdata  = 32'h0000_0000;
         if (rd_addr == CTRL_ADDR) begin
            r_nxt.rdata[CTRL_PWR]  = r_r.ctrl.pwr;
            r_nxt.rdata[CTRL_RC]   = r_r.ctrl.rc_sel;
            r_nxt.rdata[CTRL_SIDL] = r_r.ctrl.sidl;
            r_nxt.rdata[CTRL_IE]   = r_r.ctrl.ie;
            r_nxt.rdata[CTRL_FORM_L +: 2] = r_r.ctrl.form;
         end else if (rd_addr == STATUS_ADDR) begin
            r_nxt.rdata[0] = (r_r.st != CV_IDLE);
            r_nxt.rdata[1] = r_r.sleep_off;
            r_nxt.rdata[2 +: BUF_AW] = r_r.wptr;
         end else if (rd_addr == RESULT_ADDR) begin
            r_nxt.rdata[15:0] = fmt_word(r_r.ctrl.form, r_r.last);
         end else if (rd_addr >= BUF_BASE && rd_addr < BUF_BASE + 12'(4*BUF_DEPTH)
                      && rd_addr[1:0] == 2'b00) begin
            r_nxt.rdata[15:0] = fmt_word(r_r.ctrl.form,
                                         result_buffer[rd_addr[2 +: BUF_AW]]);
         end else begin
            r_nxt.rresp = RESP_SLVERR;
         end
      end
      if (r_r.rvalid && s_rready_i) begin
         r_nxt.rvalid = 1'b0;
      end

      // ---- converter clocking
      // clocks run when powered, not in sleep unless rc, not halted by idle
      run_ok = r_r.ctrl.pwr && !r_r.sleep_off
               && (!sleep_w || r_r.ctrl.rc_sel)
               && !(idle_w && r_r.ctrl.sidl);
      r_nxt.clk_en = run_ok;

      // ---- conversion sequencer
      case (r_r.st)
         CV_IDLE: begin
            // software must allow core settling after power-up before this
            if (start_req && run_ok) begin
               // the start bit may share its word with the clock choice
               if (r_nxt.ctrl.rc_sel) begin
                  r_nxt.st  = CV_DELAY;
                  r_nxt.dly = 4'(INSTR_CYC);
               end else begin
                  r_nxt.st    = CV_RUN;
                  r_nxt.start = 1'b1;
               end
               r_nxt.conversion_active_in_sleep = 1'b0;
            end
         end
         CV_DELAY: begin
            if (!run_ok) begin
               r_nxt.st    = CV_IDLE;
               r_nxt.abort = 1'b1;
            end else if (r_r.dly <= 4'h1) begin
               r_nxt.st    = CV_RUN;
               r_nxt.start = 1'b1;
            end else begin
               r_nxt.dly = r_r.dly - 4'h1;
            end
         end
         CV_RUN: begin
            if (sleep_w) begin
               r_nxt.conversion_active_in_sleep = 1'b1;
            end
            if (!run_ok) begin
               // partial conversions are dropped, never resumed
               r_nxt.st    = CV_IDLE;
               r_nxt.abort = 1'b1;
            end else if (done_w) begin
               r_nxt.st   = CV_IDLE;
               buf_we     = 1'b1;
               r_nxt.last = data_s2_r;
               r_nxt.wptr = r_r.wptr + 1'b1;
               r_nxt.irq  = 1'b1;
               if (sleep_w || r_r.conversion_active_in_sleep) begin
                  if (r_r.ctrl.ie) begin
                     r_nxt.wake = 1'b1;
                  end else begin
                     r_nxt.sleep_off = 1'b1;
                  end
               end
            end
         end
         default: begin
            r_nxt.st = CV_IDLE;
         end
      endcase

      // powering down always aborts any running conversion
      if (!r_r.ctrl.pwr && r_r.st != CV_IDLE) begin
         r_nxt.st    = CV_IDLE;
         r_nxt.abort = 1'b1;
      end
      // registered copies so that every port comes straight from a flop;
      // each follows the next state, so none of these four lags what it reports; clk_en is formed from the current state and trails by a cycle
      r_nxt.go     = r_nxt.awr & r_nxt.wr;
      r_nxt.arr    = ~r_nxt.rvalid;
      r_nxt.pwr_o  = r_nxt.ctrl.pwr & ~r_nxt.sleep_off;
      r_nxt.active = (r_nxt.st != CV_IDLE);
   end

   // -------------------------------------------------------------
   // registers
   // -------------------------------------------------------------
   // reset returns control to off and drops any sequence
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         r_r.ctrl          <= '{pwr: 1'b0, rc_sel: 1'b0, sidl: 1'b0, ie: 1'b0, form: FMT_UINT};
         r_r.st            <= CV_IDLE;
         r_r.dly           <= 4'h0;
         r_r.sleep_off     <= 1'b0;
         r_r.conversion_active_in_sleep <= 1'b0;
         r_r.wptr          <= '0;
         r_r.last          <= 12'h000;
         r_r.awr           <= 1'b0;
         r_r.wr            <= 1'b0;
         r_r.bvalid        <= 1'b0;
         r_r.bresp         <= RESP_OKAY;
         // arready sits high out of reset, no read answer is pending
         r_r.arr           <= 1'b1;
         r_r.rvalid        <= 1'b0;
         r_r.rdata         <= 32'h0000_0000;
         r_r.rresp         <= RESP_OKAY;
         r_r.clk_en        <= 1'b0;
         r_r.start         <= 1'b0;
         r_r.abort         <= 1'b1;
         r_r.irq           <= 1'b0;
         r_r.wake          <= 1'b0;
         r_r.go            <= 1'b0;
         r_r.pwr_o         <= 1'b0;
         r_r.active        <= 1'b0;
      end else begin
         r_r <= r_nxt;
      end
   end

   // buffer has no reset so its words persist across device reset
   always_ff @(posedge clk_i) begin
      if (buf_we) begin
         result_buffer[r_r.wptr] <= data_s2_r;
      end
   end

   // -------------------------------------------------------------
   // outputs
   // -------------------------------------------------------------
   // every port is a flop of the state record
   assign s_awready_o         = r_r.go;
   assign s_wready_o          = r_r.go;
   assign s_bvalid_o          = r_r.bvalid;
   assign s_bresp_o           = r_r.bresp;
   assign s_arready_o         = r_r.arr;
   assign s_rvalid_o          = r_r.rvalid;
   assign s_rdata_o           = r_r.rdata;
   assign s_rresp_o           = r_r.rresp;
   assign core_clk_en_o       = r_r.clk_en;
   assign core_power_o        = r_r.pwr_o;
   assign core_start_o        = r_r.start;
   assign core_abort_o        = r_r.abort;
   assign conversion_active_irq_o          = r_r.irq;
   assign wake_o              = r_r.wake;
   assign conversion_active_o = r_r.active;

endmodule : adc_power_sleep_format_ctrl
`default_nettype wire
